/* File: hdl/eeprom_pkg.sv */
// Functional notes
// RULE_01: acknowledge low in ninth clock after start plus matching slave address byte.
// RULE_02: in a write, acknowledge every received word address and data byte.
// RULE_03: transmitter releases data after eight bits; receiver pulls low in ninth clock.
// RULE_04: host acknowledge low without stop makes the next address byte follow.
// RULE_05: host ends read with high acknowledge then stop; device stops sending.
// RULE_06: upper four slave address bits must equal the device type code.
// RULE_07: larger variants match the next three bits against the chip address pins.
// RULE_08: smallest variant uses those three bits as page-select high address bits.
// RULE_09: slave address bit zero picks direction: 0 write, 1 read.
// RULE_10: store from the given address; program only on stop after whole byte.
// RULE_11: refuse every command during the internal program time, at most 5 ms.
// RULE_12: page write takes 16, 32 or 64 bytes; extra bytes wrap to page start.
// RULE_13: smallest variant increments only the low 4 address bits in page write.
// RULE_14: 32-byte pages keep upper address bits, increment low 5 bits.
// RULE_15: 64-byte pages keep upper 9 or 10 bits, increment low bits.
// RULE_16: word address bits above the variant capacity are ignored.
// RULE_17: a whole page programs in one interval, not one per byte.
// RULE_18: write-protect high blocks every write; low permits all writes.
// RULE_19: write-protect rising during programming aborts it at once.
// RULE_20: random read returns the byte at the address loaded just before.
// RULE_21: current read returns the held address, last accessed plus one.
// RULE_22: host releases data during dummy clocks of a software reset sequence.
// RULE_23: while programming, give no acknowledge so the host can poll.
// RULE_24: commands open with start and may close with stop, both with clock high.
// RULE_25: start then stop cancels a command; held read address then undefined.
// RULE_26: after reset or a cancel, stay idle until a fresh start.
package eeprom_pkg;

	// =====================================================================
	// timing
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned PROG_TIME_MS  = 5;
	// longest time, so the division rounds down
	localparam int unsigned PROG_CYCLES   =
		(PROG_TIME_MS * 1_000_000) / CLK_PERIOD_NS;

	// =====================================================================
	// address and frame layout
	localparam int unsigned MAX_ADDR_BITS = 15;
	localparam int unsigned DEF_ADDR_BITS = 15;
	localparam int unsigned DEF_PAGE_BITS = 6;
	localparam int unsigned TYPE_MSB      = 7;
	localparam int unsigned TYPE_LSB      = 4;
	localparam int unsigned SEL_MSB       = 3;
	localparam int unsigned SEL_LSB       = 1;
	localparam int unsigned RW_BIT        = 0;
	localparam logic [3:0]  LAST_BIT      = 4'h7;
	localparam logic [3:0]  ACK_BIT       = 4'h8;
	localparam logic        RW_READ       = 1'b1;
	// arbitrary value, not tied to any real part
	localparam logic [3:0]  DEV_TYPE_CODE = 4'h5;

	// =====================================================================
	// reset values
	localparam logic [3:0]  CNT_RST       = 4'h0;
	localparam logic [7:0]  BYTE_RST      = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_AHI,
		ST_ALO,
		ST_WDAT,
		ST_RDAT
	} state_t;

	// one byte headed for the array's page latch
	typedef struct packed {
		logic [MAX_ADDR_BITS-1:0] addr;
		logic [7:0]               data;
	} latch_wr_t;

endpackage

/* File: hdl/serial_eeprom_i2c_target.sv */
module serial_eeprom_i2c_target #(
	parameter int unsigned ADDR_BITS     = eeprom_pkg::DEF_ADDR_BITS,
	parameter int unsigned PAGE_BITS     = eeprom_pkg::DEF_PAGE_BITS,
	parameter bit          SMALL_VARIANT = 1'b0,
	parameter int unsigned PROG_CYCLES   = eeprom_pkg::PROG_CYCLES
) (
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_b_i,
	input  wire logic                  ce_i,
	input  wire logic                  scl_i,
	input  wire logic                  sda_i,
	output logic                       sda_o,
	output logic                       sda_oe_b_o,
	input  wire logic                  wp_i,
	input  wire logic                  chip_addr_pin_0_i,
	input  wire logic                  chip_addr_pin_1_i,
	input  wire logic                  chip_addr_pin_2_i,
	output logic [ADDR_BITS-1:0]       rd_addr_o,
	input  wire logic [7:0]            rd_data_i,
	output eeprom_pkg::latch_wr_t      lat_wr_o,
	output logic                       lat_we_o,
	output logic                       lat_clr_o,
	output logic                       prog_go_o,
	output logic                       prog_abort_o,
	output logic                       busy_o
);
	import eeprom_pkg::*;

	localparam int unsigned TW = $clog2(PROG_CYCLES + 1);

	// =====================================================================
	// pin synchronisers
	logic [5:0]           meta_q;
	logic [5:0]           sync_q;
	logic                 scl_p_q;
	logic                 sda_p_q;
	logic                 scl_s;
	logic                 sda_s;
	logic                 wp_s;
	logic [2:0]           pins_s;
	logic                 rise_w;
	logic                 fall_w;
	logic                 start_w;
	logic                 stop_w;
	logic [7:0]           byte_w;
	logic                 byte_end_w;
	logic                 dev_match_w;

	state_t               state_q;
	logic [3:0]           cnt_q;
	logic [7:0]           sh_q;
	logic                 ack_go_q;
	logic [ADDR_BITS-1:0] addr_q;
	logic [7:0]           tx_q;
	logic                 oe_b_q;
	logic                 loaded_q;
	logic                 busy_q;
	logic [TW-1:0]        timer_q;
	latch_wr_t            lat_q;
	logic                 lat_we_q;
	logic                 lat_clr_q;
	logic                 go_q;
	logic                 abort_q;

	// two stages per pin; logic looks only at sync_q and the scl_p_q and sda_p_q copies taken from it
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			meta_q  <= 6'h3f;
			sync_q  <= 6'h3f;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else if (ce_i) begin
			meta_q  <= {scl_i, sda_i, wp_i, chip_addr_pin_2_i,
				chip_addr_pin_1_i, chip_addr_pin_0_i};
			sync_q  <= meta_q;
			scl_p_q <= sync_q[5];
			sda_p_q <= sync_q[4];
		end
	end

	assign scl_s  = sync_q[5];
	assign sda_s  = sync_q[4];
	assign wp_s   = sync_q[3];
	assign pins_s = sync_q[2:0];

	// =====================================================================
	// bus events
	// data edges while the clock stays high are framing, not bits
	assign rise_w  = scl_s & ~scl_p_q;
	assign fall_w  = ~scl_s & scl_p_q;
	assign start_w = scl_s & scl_p_q & sda_p_q & ~sda_s;  // see RULE_24
	assign stop_w  = scl_s & scl_p_q & ~sda_p_q & sda_s;  // see RULE_24
	assign byte_w  = {sh_q[6:0], sda_s};
	assign byte_end_w = rise_w && (cnt_q == LAST_BIT) && (state_q != ST_IDLE);

	// busy refuses the address, which is what acknowledge polling sees
	assign dev_match_w =
		(byte_w[TYPE_MSB:TYPE_LSB] == DEV_TYPE_CODE) &&       // see RULE_06
		(SMALL_VARIANT ||                                      // see RULE_08
		 (byte_w[SEL_MSB:SEL_LSB] == pins_s)) &&               // see RULE_07
		!busy_q;                                               // see RULE_23

	// =====================================================================
	// frame sequencer
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			state_q  <= ST_IDLE;                               // see RULE_26
			cnt_q    <= CNT_RST;
			sh_q     <= BYTE_RST;
			ack_go_q <= 1'b0;
		end else if (ce_i) begin
			if (start_w) begin
				state_q  <= ST_DEV;
				cnt_q    <= CNT_RST;
				ack_go_q <= 1'b0;
			end else if (stop_w) begin
				state_q  <= ST_IDLE;                           // see RULE_25
				cnt_q    <= CNT_RST;
				ack_go_q <= 1'b0;
			end else if (rise_w && state_q != ST_IDLE) begin
				if (cnt_q == ACK_BIT) begin
					cnt_q    <= CNT_RST;
					ack_go_q <= 1'b0;
					// host left acknowledge high: stop sending
					if (!ack_go_q && state_q == ST_RDAT && sda_s)
						state_q <= ST_IDLE;                    // see RULE_05
				end else begin
					sh_q  <= byte_w;
					cnt_q <= cnt_q + 4'h1;
					if (cnt_q == LAST_BIT) begin
						case (state_q)
						ST_DEV: begin
							if (dev_match_w) begin
								ack_go_q <= 1'b1;              // see RULE_01
								if (byte_w[RW_BIT] == RW_READ)
									state_q <= ST_RDAT;        // see RULE_09
								else if (SMALL_VARIANT)
									state_q <= ST_ALO;
								else
									state_q <= ST_AHI;
							end else begin
								state_q <= ST_IDLE;
							end
						end
						ST_AHI: begin
							ack_go_q <= 1'b1;                  // see RULE_02
							state_q  <= ST_ALO;
						end
						ST_ALO: begin
							ack_go_q <= 1'b1;                  // see RULE_02
							state_q  <= ST_WDAT;
						end
						ST_WDAT: ack_go_q <= 1'b1;             // see RULE_02
						ST_RDAT: ack_go_q <= 1'b0;             // see RULE_03
						default: state_q <= ST_IDLE;
						endcase
					end
				end
			end
		end
	end

	// =====================================================================
	// held address and transmit byte
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			addr_q <= '0;
			tx_q   <= BYTE_RST;
		end else if (ce_i) begin
			if (byte_end_w) begin
				case (state_q)
				ST_DEV: begin
					if (SMALL_VARIANT && dev_match_w)
						addr_q[ADDR_BITS-1 -: 3] <=
							byte_w[SEL_MSB:SEL_LSB];           // see RULE_08
				end
				// bits beyond capacity are simply not stored
				ST_AHI: addr_q[ADDR_BITS-1:8] <=
					byte_w[ADDR_BITS-9:0];                     // see RULE_16
				ST_ALO: addr_q[7:0] <= byte_w;                 // see RULE_20
				// only the in-page bits count, so the page wraps
				ST_WDAT: addr_q[PAGE_BITS-1:0] <=
					addr_q[PAGE_BITS-1:0] + 1'b1; // see RULE_12 RULE_13 RULE_14 RULE_15
				ST_RDAT: addr_q <= addr_q + 1'b1;              // see RULE_21
				default: addr_q <= addr_q;
				endcase
			end else if (rise_w && cnt_q == ACK_BIT && state_q == ST_RDAT &&
				(ack_go_q || !sda_s)) begin
				tx_q <= rd_data_i;                             // see RULE_04
			end
		end
	end

	assign rd_addr_o = addr_q;

	// =====================================================================
	// data line driver, changes on clock falls and is released by a start or stop
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			oe_b_q <= 1'b1;
		end else if (ce_i) begin
			if (start_w || stop_w) begin
				oe_b_q <= 1'b1;
			end else if (fall_w) begin
				if (cnt_q == ACK_BIT && ack_go_q)
					oe_b_q <= 1'b0;                            // see RULE_03
				else if (state_q == ST_RDAT && cnt_q < ACK_BIT)
					oe_b_q <= tx_q[3'(LAST_BIT - cnt_q)];
				else
					oe_b_q <= 1'b1;                            // see RULE_03
			end
		end
	end

	// open drain: only ever pulls low
	assign sda_o      = 1'b0;
	assign sda_oe_b_o = oe_b_q;

	// =====================================================================
	// page latch loading and the internal program interval
	// the array holds the page; one program pulse covers all of it
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			lat_q     <= '0;
			lat_we_q  <= 1'b0;
			lat_clr_q <= 1'b0;
			loaded_q  <= 1'b0;
			go_q      <= 1'b0;
			abort_q   <= 1'b0;
			busy_q    <= 1'b0;
			timer_q   <= '0;
		end else if (ce_i) begin
			lat_we_q  <= 1'b0;
			lat_clr_q <= 1'b0;
			go_q      <= 1'b0;
			abort_q   <= 1'b0;
			if (byte_end_w && state_q == ST_WDAT) begin
				lat_q.addr <= MAX_ADDR_BITS'(addr_q);          // see RULE_10
				lat_q.data <= byte_w;
				lat_we_q   <= 1'b1;
				loaded_q   <= 1'b1;
			end else if (stop_w) begin
				loaded_q <= 1'b0;
				// the stop's own clock rise already took one bit, so a
				// stop after the acknowledge arrives with a count of one
				if (state_q == ST_WDAT && loaded_q && !wp_s &&
					(cnt_q == CNT_RST || cnt_q == CNT_RST + 4'h1)) begin
					go_q    <= 1'b1;               // see RULE_10 RULE_18
					busy_q  <= 1'b1;                           // see RULE_17
					timer_q <= TW'(PROG_CYCLES);               // see RULE_11
				end else if (loaded_q) begin
					lat_clr_q <= 1'b1;                         // see RULE_18
				end
			end else if (start_w && loaded_q) begin
				loaded_q  <= 1'b0;
				lat_clr_q <= 1'b1;
			end
			if (busy_q) begin
				if (wp_s) begin
					busy_q  <= 1'b0;                           // see RULE_19
					abort_q <= 1'b1;
				end else begin
					timer_q <= timer_q - 1'b1;
					if (timer_q == TW'(1))
						busy_q <= 1'b0;                        // see RULE_11
				end
			end
		end
	end

	assign lat_wr_o     = lat_q;
	assign lat_we_o     = lat_we_q;
	assign lat_clr_o    = lat_clr_q;
	assign prog_go_o    = go_q;
	assign prog_abort_o = abort_q;
	assign busy_o       = busy_q;

	// =====================================================================
	// checks
	a_dev_ack: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see RULE_01
		ce_i && byte_end_w && state_q == ST_DEV && dev_match_w |=>
		ack_go_q && cnt_q == ACK_BIT)
		else $error("matching address not acknowledged");

	a_busy_noack: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see RULE_23
		ce_i && byte_end_w && state_q == ST_DEV && busy_q |=>
		!ack_go_q && state_q == ST_IDLE)
		else $error("address acknowledged while busy");

	a_ack_drive: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see RULE_03
		ce_i && fall_w && !start_w && cnt_q == ACK_BIT && ack_go_q |=>
		!sda_oe_b_o ##1 !sda_oe_b_o)
		else $error("acknowledge not driven low");

	a_write_ack: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see RULE_02
		ce_i && byte_end_w && state_q inside {ST_AHI, ST_ALO, ST_WDAT} |=>
		ack_go_q)
		else $error("write byte not acknowledged");

	a_prog_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see RULE_10
		prog_go_o |-> $past(stop_w) && $past(state_q) == ST_WDAT &&
		$past(loaded_q) && busy_o)
		else $error("program started without stop after data");

	a_wp_block: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see RULE_18
		prog_go_o |-> !$past(wp_s))
		else $error("program started while protected");

	a_wp_abort: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see RULE_19
		ce_i && busy_o && wp_s |=> !busy_o && prog_abort_o)
		else $error("protect did not abort programming");

	a_busy_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see RULE_11
		ce_i && busy_o && !wp_s && timer_q > TW'(1) |=> busy_o)
		else $error("busy dropped early");

	a_page_wrap: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see RULE_12
		lat_we_o |-> addr_q[ADDR_BITS-1:PAGE_BITS] ==
		lat_wr_o.addr[ADDR_BITS-1:PAGE_BITS] &&
		addr_q[PAGE_BITS-1:0] == lat_wr_o.addr[PAGE_BITS-1:0] + 1'b1)
		else $error("page address left its page");

	a_nack_end: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see RULE_05
		ce_i && rise_w && !start_w && !stop_w && cnt_q == ACK_BIT &&
		!ack_go_q && state_q == ST_RDAT && sda_s |=>
		state_q == ST_IDLE ##1 sda_oe_b_o)
		else $error("read continued after missing acknowledge");

	a_stop_idle: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i) // see RULE_25
		ce_i && stop_w |=> state_q == ST_IDLE && sda_oe_b_o)
		else $error("stop did not return to idle");

	// a freeze must hold every concern, the program timer included
	a_ce_freeze: assert property (@(posedge ref_clk_i) // see RULE_11
		disable iff (!rst_b_i)
		!ce_i |=> $stable(state_q) && $stable(addr_q) && $stable(busy_q) &&
		$stable(timer_q))
		else $error("state moved while clock enable low");

	a_rd_step: assert property (@(posedge ref_clk_i) // see RULE_21
		disable iff (!rst_b_i)
		ce_i && byte_end_w && state_q == ST_RDAT |=>
		rd_addr_o == $past(rd_addr_o) + 1'b1)
		else $error("read address did not step");

	a_type_refuse: assert property (@(posedge ref_clk_i) // see RULE_06
		disable iff (!rst_b_i)
		ce_i && byte_end_w && state_q == ST_DEV &&
		byte_w[TYPE_MSB:TYPE_LSB] != DEV_TYPE_CODE |=>
		state_q == ST_IDLE && !ack_go_q)
		else $error("foreign type code accepted");

endmodule // serial_eeprom_i2c_target

/* File: tb/bus_host.sv */
module bus_host (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// =====================================================
	// lines released, clock parked high outside frames
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// =====================================================
	// move just after a ref clock edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// data falls with clock high; also a repeated start
	task automatic start();
		sda_o = 1'b1;
		tick(2);
		scl_o = 1'b1;
		tick(2);
		sda_o = 1'b0;
		tick(2);
		scl_o = 1'b0;
		tick(2);
	endtask

	// data rises with clock high, line left released
	task automatic stop();
		sda_o = 1'b0;
		tick(2);
		scl_o = 1'b1;
		tick(2);
		sda_o = 1'b1;
		tick(4);
	endtask

	// msb first, then the ninth bit; a 1 releases the line so the
	// wire shows what the device drives (sampled late in high phase)
	task automatic byte_io(input logic [7:0] b, input logic ninth,
		output logic [7:0] r, output logic s);
		logic [8:0] v;
		v = {b, ninth};
		for (int i = 8; i >= 0; i--) begin
			sda_o = v[i];
			tick(2);
			scl_o = 1'b1;
			tick(4);
			if (i > 0)
				r[i-1] = sda_i;
			else
				s = sda_i;
			scl_o = 1'b0;
			tick(2);
		end
	endtask
endmodule // bus_host

/* File: tb/serial_eeprom_i2c_target_test.sv */
module serial_eeprom_i2c_target_test;
	timeunit 1ns;
	timeprecision 100ps;
	import eeprom_pkg::*;

	// =====================================================
	// short program time and 4-byte pages keep the run brief
	localparam int unsigned PROG  = 200;
	localparam int unsigned LIMIT = 20000;
	localparam logic [7:0]  DW    = {DEV_TYPE_CODE, 3'b101, 1'b0};
	localparam logic [7:0]  DR    = {DEV_TYPE_CODE, 3'b101, 1'b1};

	logic        clk   = 1'b0;
	logic        rst_b = 1'b0;
	logic        wp    = 1'b0;
	logic        ce    = 1'b1;
	logic [2:0]  strap = 3'b101;
	logic        scl;
	logic        hsda;
	logic        sda_o;
	logic        oe_b;
	logic        lat_we;
	logic        lat_clr;
	logic        go;
	logic        abort;
	logic        busy;
	logic [14:0] rd_addr;
	logic [7:0]  rb;
	logic        nack;
	latch_wr_t   lat_wr;
	latch_wr_t   wq[$];
	int          errors;
	int          n_checks;
	int          cyc;
	int          n_go;
	int          n_clr;
	int          n_abort;
	int          blen;

	// open drain wire with pull-up
	wire logic       sda     = hsda & (oe_b | sda_o);
	// array stand-in: each byte derived from its own address
	wire logic [7:0] rd_data = rd_addr[7:0] + {1'b0, rd_addr[14:8]};

	always #12.5 clk = ~clk;

	serial_eeprom_i2c_target #(.ADDR_BITS(15), .PAGE_BITS(2),
		.SMALL_VARIANT(1'b0), .PROG_CYCLES(PROG)) DUT (
		.ref_clk_i(clk), .rst_b_i(rst_b), .ce_i(ce), .scl_i(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_b_o(oe_b), .wp_i(wp),
		.chip_addr_pin_0_i(strap[0]), .chip_addr_pin_1_i(strap[1]),
		.chip_addr_pin_2_i(strap[2]), .rd_addr_o(rd_addr),
		.rd_data_i(rd_data), .lat_wr_o(lat_wr), .lat_we_o(lat_we),
		.lat_clr_o(lat_clr), .prog_go_o(go), .prog_abort_o(abort),
		.busy_o(busy));

	bus_host host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(hsda));

	// =====================================================
	// watch the array side; a hang counts as a mismatch
	always @(posedge clk) begin
		cyc++;
		if (lat_we === 1'b1)
			wq.push_back(lat_wr);
		if (go === 1'b1) begin
			n_go++;
			blen = 0;
		end
		if (busy === 1'b1)
			blen++;
		if (lat_clr === 1'b1)
			n_clr++;
		if (abort === 1'b1)
			n_abort++;
		if (cyc == LIMIT) begin
			errors++;
			test_done();
		end
	end

	// =====================================================
	// helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// host sends a byte; device answer on the ninth clock
	task automatic put(input logic [7:0] b, input logic ack);
		host.byte_io(b, 1'b1, rb, nack);
		check(!nack, ack);
	endtask

	// host reads a byte; ninth low acks, high ends the read
	task automatic get(input logic ninth, input logic [7:0] exp);
		host.byte_io(8'hFF, ninth, rb, nack);
		check(rb, exp);
		check(nack, ninth);
	endtask

	// bounded wait, polling too long would hide a stuck busy
	task automatic wait_idle();
		for (int i = 0; i < 400 && busy === 1'b1; i++)
			host.tick(1);
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// =====================================================
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		#1 rst_b = 1'b1;
		host.tick(4);
		// selection: wrong type code, wrong strap, then a match
		host.start();
		put({DEV_TYPE_CODE ^ 4'h1, 3'b101, 1'b0}, 1'b0);
		host.start();
		put({DEV_TYPE_CODE, 3'b100, 1'b0}, 1'b0);
		host.start();
		put(DW, 1'b1);
		put(8'hF2, 1'b1);
		put(8'h3C, 1'b1);
		put(8'hA5, 1'b1);
		host.stop();
		host.tick(6);
		check(wq.pop_front(), {15'h723C, 8'hA5});
		check(n_go, 1);
		check(busy, 1'b1);
		// clock enable low freezes the program timer for 50 cycles
		ce = 1'b0;
		host.tick(50);
		ce = 1'b1;
		// polling while programming gets no answer
		host.start();
		put(DW, 1'b0);
		host.stop();
		wait_idle();
		check(blen, PROG + 50);
		// page write of five bytes into a four-byte page
		host.start();
		put(DW, 1'b1);
		put(8'h01, 1'b1);
		put(8'h0E, 1'b1);
		for (int i = 0; i < 5; i++)
			put(8'h10 + i[7:0], 1'b1);
		host.stop();
		host.tick(6);
		for (int i = 0; i < 5; i++)
			check(wq.pop_front(), {13'h0043, 2'b10 + i[1:0], 8'h10 + i[7:0]});
		check(n_go, 2);
		wait_idle();
		// protected write is acked but discarded
		wp = 1'b1;
		host.start();
		put(DW, 1'b1);
		put(8'h00, 1'b1);
		put(8'h00, 1'b1);
		put(8'h77, 1'b1);
		host.stop();
		host.tick(6);
		check(n_clr, 1);
		check(n_go, 2);
		wp = 1'b0;
		// protect rising mid-program aborts at once
		host.start();
		put(DW, 1'b1);
		put(8'h00, 1'b1);
		put(8'h10, 1'b1);
		put(8'h33, 1'b1);
		host.stop();
		host.tick(10);
		wp = 1'b1;
		host.tick(6);
		check(n_abort, 1);
		check(busy, 1'b0);
		wp = 1'b0;
		// random read, sequential step, then a current read
		host.start();
		put(DW, 1'b1);
		put(8'h12, 1'b1);
		put(8'h34, 1'b1);
		host.start();
		put(DR, 1'b1);
		get(1'b0, 8'h46);
		get(1'b1, 8'h47);
		host.stop();
		host.start();
		put(DR, 1'b1);
		get(1'b1, 8'h48);
		host.stop();
		// cancel, then a byte whose leading low bit forms a start; the shifted byte is refused
		host.start();
		host.stop();
		put(DW, 1'b0);
		// reset: start, nine released clocks, start, command
		host.start();
		host.byte_io(8'hFF, 1'b1, rb, nack);
		host.start();
		put(DW, 1'b1);
		host.stop();
		// re-strapped pins move the answering address
		strap = 3'b011;
		host.tick(4);
		host.start();
		put({DEV_TYPE_CODE, 3'b011, 1'b0}, 1'b1);
		host.start();
		put(DW, 1'b0);
		host.stop();
		test_done();
	end
endmodule // serial_eeprom_i2c_target_test
